// ==== design/mie_pkg.sv ====
// Purpose: Shared constants and types of the instruction execution subset
// Assumes: One instruction cycle lasts four system clocks
// Notes: Opcode codes outside the enumeration execute as idle

package mie_pkg;

    localparam int DATA_W = 8;
    localparam int PC_W = 13;
    localparam int SP_W = 3;
    localparam int STACK_DEPTH = 8;
    localparam int BUSY_W = 4;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam logic [BUSY_W-1:0] CLKS_PER_CYCLE = 4'h4;
    localparam logic [BUSY_W-1:0] CYC_ONE = 4'h1;
    localparam logic [BUSY_W-1:0] CYC_TWO = 4'h2;

    // ------------------------------------------------------------------
    // Addresses and limits
    // ------------------------------------------------------------------
    localparam logic [DATA_W-1:0] PC_LOW_BYTE_ADDR = 8'h06;
    localparam logic [DATA_W-1:0] WDT_PRE_MAX = 8'hff;
    localparam logic [DATA_W-1:0] WDT_CNT_MAX = 8'hff;
    localparam logic [DATA_W-1:0] BCD_LIMIT = 8'h09;
    localparam logic [DATA_W-1:0] BCD_STEP = 8'h06;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [DATA_W-1:0] RST_WORK_REG = 8'h00;
    localparam logic [PC_W-1:0] RST_PC = 13'h0000;
    localparam logic [DATA_W-1:0] WDT_ZERO = 8'h00;

    typedef enum logic [4:0] {
        OP_WDT_CLEAR, OP_WDT_PRE1, OP_WDT_PRE2,
        OP_INV_MEM, OP_INV_WORK, OP_BCD_ADJ,
        OP_DEC_MEM, OP_DEC_WORK, OP_INC_MEM, OP_INC_WORK,
        OP_POWER_DOWN, OP_JUMP,
        OP_COPY_IMM, OP_COPY_MEM_TO_WORK, OP_COPY_WORK_TO_MEM,
        OP_OR_IMM, OP_OR_MEM, OP_OR_TO_RAM,
        OP_SUB_EXIT, OP_SUB_EXIT_IMM, OP_IRQ_EXIT, OP_IDLE
    } mie_op_t;

    typedef struct packed {
        mie_op_t op;
        logic [DATA_W-1:0] imm;
        logic [PC_W-1:0] jumpAddr;
        logic [DATA_W-1:0] memAddr;
        logic [DATA_W-1:0] memData;
    } mie_instr_t;

    typedef struct packed {
        logic zero;
        logic carry;
        logic halfCarry;
        logic overflow;
        logic sleepFlag;
        logic watchdogExpired;
    } mie_flags_t;

    localparam mie_flags_t RST_FLAGS = '0;

    typedef struct packed {
        logic en;
        logic [DATA_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } mie_mem_wr_t;

endpackage

// ==== design/mie_pc_stack.sv ====
// Purpose: Hardware return stack of program counter values
// Assumes: Push and pop never occur in the same cycle
// Notes: Pointer wraps at the stack depth; top word is registered
`timescale 1ns/100ps

module mie_pc_stack (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic push,
    input wire logic [mie_pkg::PC_W-1:0] pushPc,
    input wire logic pop,
    output logic [mie_pkg::PC_W-1:0] topPc
);

    typedef struct packed {
        logic [mie_pkg::STACK_DEPTH-1:0][mie_pkg::PC_W-1:0] entry;
        logic [mie_pkg::SP_W-1:0] sp;
        logic [mie_pkg::PC_W-1:0] top;
    } mie_stack_st_t;

    mie_stack_st_t st_ff;
    mie_stack_st_t nxt_st;

    always_comb begin
        nxt_st = st_ff;
        if (push) begin
            nxt_st.entry[st_ff.sp] = pushPc;
            nxt_st.sp = st_ff.sp + 3'h1;
            nxt_st.top = pushPc;
        end else if (pop) begin
            nxt_st.sp = st_ff.sp - 3'h1;
            nxt_st.top = st_ff.entry[st_ff.sp - 3'h2];
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign topPc = st_ff.top;

endmodule

// ==== design/mie_exec_unit.sv ====
// Purpose: Executes the watchdog, logic, move, jump and return subset
// Assumes: Instruction fields and memory read data arrive together
// Notes: One instruction accepted per ready window; clock gate on sleep
`timescale 1ns/100ps

module mie_exec_unit (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic instrValid,
    input wire mie_pkg::mie_instr_t instr,
    input wire logic callPush,
    input wire logic [mie_pkg::PC_W-1:0] callReturnPc,
    input wire logic irqAccept,
    input wire logic wakeUp,
    output logic instrReady,
    output logic [mie_pkg::DATA_W-1:0] workRegister,
    output mie_pkg::mie_flags_t flags,
    output logic [mie_pkg::PC_W-1:0] programCounter,
    output logic globalIrqEnable,
    output mie_pkg::mie_mem_wr_t memWrite,
    output logic clockGateOff,
    output logic [mie_pkg::DATA_W-1:0] watchdogCounter,
    output logic watchdogPreclearFirstSeen,
    output logic watchdogPreclearSecondSeen
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [mie_pkg::DATA_W-1:0] work;
        mie_pkg::mie_flags_t flags;
        logic [mie_pkg::PC_W-1:0] pc;
        logic gie;
        logic pre1;
        logic pre2;
        logic [mie_pkg::DATA_W-1:0] wdtCnt;
        logic [mie_pkg::DATA_W-1:0] wdtPre;
        logic halted;
        logic [mie_pkg::BUSY_W-1:0] busyCnt;
        logic ready;
        mie_pkg::mie_mem_wr_t memWr;
    } mie_core_st_t;

    mie_core_st_t st_ff;
    mie_core_st_t nxt_st;

    logic accept;
    logic stackPop;
    logic [mie_pkg::PC_W-1:0] stackTop;

    assign accept = instrValid & st_ff.ready;

    // ------------------------------------------------------------------
    // Return stack
    // ------------------------------------------------------------------
    always_comb begin
        stackPop = 1'b0;
        if (accept) begin
            unique case (instr.op)
                mie_pkg::OP_SUB_EXIT,
                mie_pkg::OP_SUB_EXIT_IMM,
                mie_pkg::OP_IRQ_EXIT: stackPop = 1'b1;
                default: stackPop = 1'b0;
            endcase
        end
    end

    mie_pc_stack u_stack (
        .clock(clock),
        .sys_rst(sys_rst),
        .push(callPush),
        .pushPc(callReturnPc),
        .pop(stackPop),
        .topPc(stackTop)
    );

    // ------------------------------------------------------------------
    // Datapath helpers
    // ------------------------------------------------------------------
    logic [4:0] lowSum;
    logic lowAdjust;
    logic adjCarry;
    logic [4:0] highBase;
    logic highAdjust;
    logic [4:0] highSum;
    logic [mie_pkg::DATA_W-1:0] bcdResult;

    // Decimal adjust of the work register
    always_comb begin
        lowAdjust = ({1'b0, st_ff.work[3:0]} > mie_pkg::BCD_LIMIT[4:0])
            | st_ff.flags.halfCarry;
        lowSum = lowAdjust ?
            ({1'b0, st_ff.work[3:0]} + mie_pkg::BCD_STEP[4:0]) :
            {1'b0, st_ff.work[3:0]};
        adjCarry = lowAdjust & lowSum[4];
        highBase = {1'b0, st_ff.work[7:4]} + {4'h0, adjCarry};
        highAdjust = (highBase > mie_pkg::BCD_LIMIT[4:0])
            | st_ff.flags.carry;
        highSum = highAdjust ?
            (highBase + mie_pkg::BCD_STEP[4:0]) : highBase;
        bcdResult = {highSum[3:0], lowSum[3:0]};
    end

    logic [mie_pkg::DATA_W-1:0] invMem;
    logic [mie_pkg::DATA_W-1:0] decMem;
    logic [mie_pkg::DATA_W-1:0] incMem;
    logic [mie_pkg::DATA_W-1:0] orImm;
    logic [mie_pkg::DATA_W-1:0] orMem;

    assign invMem = ~instr.memData;
    assign decMem = instr.memData - 8'h01;
    assign incMem = instr.memData + 8'h01;
    assign orImm = st_ff.work | instr.imm;
    assign orMem = st_ff.work | instr.memData;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    logic wdtTimeout;
    logic wdtClear;
    logic [mie_pkg::BUSY_W-1:0] cycles;
    logic [mie_pkg::PC_W-1:0] pcNext;

    always_comb begin
        nxt_st = st_ff;
        nxt_st.memWr.en = 1'b0;
        wdtClear = 1'b0;
        cycles = mie_pkg::CYC_ONE;
        pcNext = st_ff.pc + 13'h0001;

        // Free-running watchdog with prescaler
        wdtTimeout = (st_ff.wdtPre == mie_pkg::WDT_PRE_MAX)
            && (st_ff.wdtCnt == mie_pkg::WDT_CNT_MAX);
        nxt_st.wdtPre = st_ff.wdtPre + 8'h01;
        if (st_ff.wdtPre == mie_pkg::WDT_PRE_MAX) begin
            nxt_st.wdtCnt = st_ff.wdtCnt + 8'h01;
        end

        if (st_ff.busyCnt != '0) begin
            nxt_st.busyCnt = st_ff.busyCnt - 4'h1;
        end

        if (irqAccept) begin
            nxt_st.gie = 1'b0;
        end

        if (accept) begin
            unique case (instr.op)
                mie_pkg::OP_WDT_CLEAR: begin
                    wdtClear = 1'b1;
                end
                mie_pkg::OP_WDT_PRE1: begin
                    if (st_ff.pre2) begin
                        wdtClear = 1'b1;
                        nxt_st.pre1 = 1'b0;
                        nxt_st.pre2 = 1'b0;
                    end else begin
                        nxt_st.pre1 = 1'b1;
                    end
                end
                mie_pkg::OP_WDT_PRE2: begin
                    if (st_ff.pre1) begin
                        wdtClear = 1'b1;
                        nxt_st.pre1 = 1'b0;
                        nxt_st.pre2 = 1'b0;
                    end else begin
                        nxt_st.pre2 = 1'b1;
                    end
                end
                mie_pkg::OP_INV_MEM: begin
                    nxt_st.memWr = '{1'b1, instr.memAddr, invMem};
                    nxt_st.flags.zero = (invMem == '0);
                end
                mie_pkg::OP_INV_WORK: begin
                    nxt_st.work = invMem;
                    nxt_st.flags.zero = (invMem == '0);
                end
                mie_pkg::OP_BCD_ADJ: begin
                    nxt_st.memWr = '{1'b1, instr.memAddr, bcdResult};
                    if (highAdjust) begin
                        nxt_st.flags.carry = 1'b1;
                    end
                end
                mie_pkg::OP_DEC_MEM: begin
                    nxt_st.memWr = '{1'b1, instr.memAddr, decMem};
                    nxt_st.flags.zero = (decMem == '0);
                end
                mie_pkg::OP_DEC_WORK: begin
                    nxt_st.work = decMem;
                    nxt_st.flags.zero = (decMem == '0);
                end
                mie_pkg::OP_INC_MEM: begin
                    nxt_st.memWr = '{1'b1, instr.memAddr, incMem};
                    nxt_st.flags.zero = (incMem == '0);
                end
                mie_pkg::OP_INC_WORK: begin
                    nxt_st.work = incMem;
                    nxt_st.flags.zero = (incMem == '0);
                end
                mie_pkg::OP_POWER_DOWN: begin
                    wdtClear = 1'b1;
                    nxt_st.halted = 1'b1;
                end
                mie_pkg::OP_JUMP: begin
                    pcNext = instr.jumpAddr;
                    cycles = mie_pkg::CYC_TWO;
                end
                mie_pkg::OP_COPY_IMM: begin
                    nxt_st.work = instr.imm;
                end
                mie_pkg::OP_COPY_MEM_TO_WORK: begin
                    nxt_st.work = instr.memData;
                end
                mie_pkg::OP_COPY_WORK_TO_MEM: begin
                    nxt_st.memWr = '{1'b1, instr.memAddr, st_ff.work};
                end
                mie_pkg::OP_OR_IMM: begin
                    nxt_st.work = orImm;
                    nxt_st.flags.zero = (orImm == '0);
                end
                mie_pkg::OP_OR_MEM: begin
                    nxt_st.work = orMem;
                    nxt_st.flags.zero = (orMem == '0);
                end
                mie_pkg::OP_OR_TO_RAM: begin
                    nxt_st.memWr = '{1'b1, instr.memAddr, orMem};
                    nxt_st.flags.zero = (orMem == '0);
                end
                mie_pkg::OP_SUB_EXIT: begin
                    pcNext = stackTop;
                    cycles = mie_pkg::CYC_TWO;
                end
                mie_pkg::OP_SUB_EXIT_IMM: begin
                    pcNext = stackTop;
                    nxt_st.work = instr.imm;
                    cycles = mie_pkg::CYC_TWO;
                end
                mie_pkg::OP_IRQ_EXIT: begin
                    pcNext = stackTop;
                    nxt_st.gie = 1'b1;
                    cycles = mie_pkg::CYC_TWO;
                end
                default: begin
                    // Idle and unknown codes only advance the PC
                end
            endcase

            // Memory result landing on the PC low byte redirects flow
            if (nxt_st.memWr.en
                && (instr.memAddr == mie_pkg::PC_LOW_BYTE_ADDR)) begin
                pcNext = {st_ff.pc[mie_pkg::PC_W-1:8], nxt_st.memWr.data};
                cycles = cycles + mie_pkg::CYC_ONE;
            end

            nxt_st.pc = pcNext;
            nxt_st.busyCnt = 4'((cycles * mie_pkg::CLKS_PER_CYCLE) - 4'h1);
        end

        // Watchdog clear and power-down entry
        if (wdtClear) begin
            nxt_st.wdtCnt = mie_pkg::WDT_ZERO;
            nxt_st.wdtPre = mie_pkg::WDT_ZERO;
            nxt_st.flags.watchdogExpired = 1'b0;
            nxt_st.flags.sleepFlag = (accept
                && (instr.op == mie_pkg::OP_POWER_DOWN));
        end

        // Timeout set wins over a clear in the same cycle
        if (wdtTimeout) begin
            nxt_st.flags.watchdogExpired = 1'b1;
        end

        // Leave power-down on wake request or watchdog timeout
        if (st_ff.halted && (wakeUp || wdtTimeout)) begin
            nxt_st.halted = 1'b0;
        end

        nxt_st.ready = (nxt_st.busyCnt == '0) && !nxt_st.halted;
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            st_ff.work <= mie_pkg::RST_WORK_REG;
            st_ff.flags <= mie_pkg::RST_FLAGS;
            st_ff.pc <= mie_pkg::RST_PC;
            st_ff.gie <= 1'b0;
            st_ff.pre1 <= 1'b0;
            st_ff.pre2 <= 1'b0;
            st_ff.wdtCnt <= mie_pkg::WDT_ZERO;
            st_ff.wdtPre <= mie_pkg::WDT_ZERO;
            st_ff.halted <= 1'b0;
            st_ff.busyCnt <= '0;
            st_ff.ready <= 1'b0;
            st_ff.memWr <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign instrReady = st_ff.ready;
    assign workRegister = st_ff.work;
    assign flags = st_ff.flags;
    assign programCounter = st_ff.pc;
    assign globalIrqEnable = st_ff.gie;
    assign memWrite = st_ff.memWr;
    assign clockGateOff = st_ff.halted;
    assign watchdogCounter = st_ff.wdtCnt;
    assign watchdogPreclearFirstSeen = st_ff.pre1;
    assign watchdogPreclearSecondSeen = st_ff.pre2;

endmodule

// ==== dv/mie_exec_props.sv ====
// Purpose: Port-level checks of the execution unit
// Assumes: An instruction is taken when valid meets ready
// Notes: Cycles where the watchdog may wrap are left out
`timescale 1ns/100ps

module mie_exec_props (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic instrValid,
    input wire mie_pkg::mie_instr_t instr,
    input wire logic callPush,
    input wire logic [mie_pkg::PC_W-1:0] callReturnPc,
    input wire logic irqAccept,
    input wire logic wakeUp,
    input wire logic instrReady,
    input wire logic [mie_pkg::DATA_W-1:0] workRegister,
    input wire mie_pkg::mie_flags_t flags,
    input wire logic [mie_pkg::PC_W-1:0] programCounter,
    input wire logic globalIrqEnable,
    input wire mie_pkg::mie_mem_wr_t memWrite,
    input wire logic clockGateOff,
    input wire logic [mie_pkg::DATA_W-1:0] watchdogCounter,
    input wire logic watchdogPreclearFirstSeen,
    input wire logic watchdogPreclearSecondSeen
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (sys_rst);

    // ------------------------------------------
    // Accept outside a watchdog wrap
    // ------------------------------------------
    logic calm;
    assign calm = instrValid && instrReady && watchdogCounter != 8'hff;

    wdt_clear_zero_a: assert property (
        calm && instr.op == mie_pkg::OP_WDT_CLEAR |=> watchdogCounter == 8'h00
        && !flags.sleepFlag && !flags.watchdogExpired)
        else $error("watchdog clear left state");
    preclear_pair_a: assert property (
        calm && instr.op == mie_pkg::OP_WDT_PRE2 && watchdogPreclearFirstSeen
        |=> watchdogCounter == 8'h00 && !flags.sleepFlag
        && !flags.watchdogExpired && !watchdogPreclearFirstSeen)
        else $error("preclear pair left state");
    preclear_single_a: assert property (
        calm && instr.op == mie_pkg::OP_WDT_PRE1 && !watchdogPreclearSecondSeen
        |=> watchdogPreclearFirstSeen && $stable(flags.sleepFlag))
        else $error("single preclear wrong");
    invert_work_a: assert property (
        calm && instr.op == mie_pkg::OP_INV_WORK |=> workRegister ==
        ~$past(instr.memData) && flags.zero == (workRegister == 8'h00))
        else $error("invert into work wrong");
    inc_mem_a: assert property (
        calm && instr.op == mie_pkg::OP_INC_MEM && instr.memAddr != 8'h06
        |=> memWrite.en && memWrite.data == $past(instr.memData) + 8'h01)
        else $error("increment to memory wrong");
    sleep_entry_a: assert property (
        calm && instr.op == mie_pkg::OP_POWER_DOWN |=> clockGateOff
        && flags.sleepFlag && !flags.watchdogExpired && watchdogCounter == 8'h00
        && programCounter == $past(programCounter) + 13'h0001)
        else $error("power-down entry wrong");
    sleep_hold_a: assert property (
        clockGateOff && !wakeUp && watchdogCounter != 8'hff |=> !instrReady
        && $stable(workRegister) && $stable(programCounter))
        else $error("power-down did not hold");
    jump_timing_a: assert property (
        calm && instr.op == mie_pkg::OP_JUMP |=> programCounter ==
        $past(instr.jumpAddr) && flags == $past(flags) && !instrReady
        ##1 !instrReady [*6] ##1 instrReady)
        else $error("jump target or timing wrong");
    idle_step_a: assert property (
        calm && instr.op == mie_pkg::OP_IDLE |=> programCounter ==
        $past(programCounter) + 13'h0001 && flags == $past(flags)
        && !instrReady ##1 !instrReady [*2] ##1 instrReady)
        else $error("idle step wrong");
    sub_exit_a: assert property (
        calm && instr.op == mie_pkg::OP_SUB_EXIT |=> flags == $past(flags)
        && !instrReady ##1 !instrReady [*6] ##1 instrReady)
        else $error("subroutine exit timing wrong");
    irq_exit_a: assert property (
        calm && instr.op == mie_pkg::OP_IRQ_EXIT |=> globalIrqEnable)
        else $error("interrupt exit left enable low");
endmodule

bind mie_exec_unit mie_exec_props u_mie_exec_props (
    .clock, .sys_rst, .instrValid, .instr, .callPush, .callReturnPc,
    .irqAccept, .wakeUp, .instrReady, .workRegister, .flags,
    .programCounter, .globalIrqEnable, .memWrite, .clockGateOff,
    .watchdogCounter, .watchdogPreclearFirstSeen, .watchdogPreclearSecondSeen
);

// ==== dv/mie_exec_unit_tb.sv ====
// Purpose: Self-checking bench for the execution unit
// Assumes: Inputs change at the falling clock edge
// Notes: Scenario tasks run in sequence
`timescale 1ns/100ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_fail++; \
    $display("wrong value at %0t: %h not %h", $time, a, b); end end

module mie_exec_unit_tb;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic instrValid = 1'b0;
    mie_pkg::mie_instr_t instr = '0;
    logic callPush = 1'b0;
    logic [12:0] callReturnPc = 13'h0000;
    logic irqAccept = 1'b0;
    logic wakeUp = 1'b0;
    logic instrReady, globalIrqEnable, clockGateOff;
    logic [7:0] workRegister, watchdogCounter;
    mie_pkg::mie_flags_t flags, f0, fx;
    logic [12:0] programCounter;
    mie_pkg::mie_mem_wr_t memWrite;
    logic watchdogPreclearFirstSeen, watchdogPreclearSecondSeen;
    logic expCarry = 1'b0;
    int n_fail = 0;
    int comparisons = 0;
    int lowCnt;

    mie_exec_unit u_mie_exec_unit (
        .clock, .sys_rst, .instrValid, .instr, .callPush, .callReturnPc,
        .irqAccept, .wakeUp, .instrReady, .workRegister, .flags,
        .programCounter, .globalIrqEnable, .memWrite, .clockGateOff,
        .watchdogCounter, .watchdogPreclearFirstSeen,
        .watchdogPreclearSecondSeen
    );

    // ------------------------------------------
    // Drivers
    // ------------------------------------------
    task automatic tally_and_finish;
        $display("comparisons %0d, mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic wait_ready;
        lowCnt = 0;
        while (instrReady !== 1'b1) begin
            lowCnt++;
            if (lowCnt > 60) begin
                n_fail++;
                $display("wrong value at %0t: ready never came", $time);
                tally_and_finish;
            end
            @(negedge clock);
        end
    endtask

    task automatic exec(input mie_pkg::mie_op_t op,
            input logic [7:0] imm = 8'h00, input logic [12:0] ja = 13'h0000,
            input logic [7:0] ma = 8'h30, input logic [7:0] md = 8'h00);
        wait_ready;
        f0 = flags;
        instr = '{op, imm, ja, ma, md};
        instrValid = 1'b1;
        @(negedge clock);
        instrValid = 1'b0;
    endtask

    task automatic alu(input mie_pkg::mie_op_t op, input logic [7:0] imm,
            input logic [7:0] md, input logic [7:0] res, input logic toMem,
            input logic zf);
        logic [7:0] w0;
        w0 = workRegister;
        exec(op, imm, 13'h0000, 8'h30, md);
        fx = f0;
        fx.carry = expCarry;
        if (zf) fx.zero = (res == 8'h00);
        `CHK(flags, fx)
        `CHK(memWrite, {toMem, toMem ? 8'h30 : memWrite.addr, toMem ? res :
            memWrite.data})
        `CHK(workRegister, toMem ? w0 : res)
        wait_ready;
        `CHK(lowCnt, 3)
    endtask

    task automatic push_pc(input logic [12:0] pc);
        callReturnPc = pc;
        callPush = 1'b1;
        @(negedge clock);
        callPush = 1'b0;
        @(negedge clock);
    endtask

    // ------------------------------------------
    // Scenarios
    // ------------------------------------------
    task automatic t_data;
        alu(mie_pkg::OP_COPY_IMM, 8'h3c, 8'h00, 8'h3c, 1'b0, 1'b0);
        alu(mie_pkg::OP_OR_IMM, 8'h41, 8'h00, 8'h7d, 1'b0, 1'b1);
        alu(mie_pkg::OP_OR_MEM, 8'h00, 8'h82, 8'hff, 1'b0, 1'b1);
        alu(mie_pkg::OP_OR_TO_RAM, 8'h00, 8'h00, 8'hff, 1'b1, 1'b1);
        alu(mie_pkg::OP_COPY_IMM, 8'h00, 8'h00, 8'h00, 1'b0, 1'b0);
        alu(mie_pkg::OP_OR_IMM, 8'h00, 8'h00, 8'h00, 1'b0, 1'b1);
        alu(mie_pkg::OP_COPY_WORK_TO_MEM, 8'h00, 8'h00, 8'h00, 1'b1,
            1'b0);
        alu(mie_pkg::OP_COPY_MEM_TO_WORK, 8'h00, 8'h9a, 8'h9a, 1'b0,
            1'b0);
        alu(mie_pkg::OP_INV_MEM, 8'h00, 8'h5a, 8'ha5, 1'b1, 1'b1);
        alu(mie_pkg::OP_INV_WORK, 8'h00, 8'hff, 8'h00, 1'b0, 1'b1);
        alu(mie_pkg::OP_DEC_MEM, 8'h00, 8'h00, 8'hff, 1'b1, 1'b1);
        alu(mie_pkg::OP_DEC_WORK, 8'h00, 8'h01, 8'h00, 1'b0, 1'b1);
        alu(mie_pkg::OP_INC_MEM, 8'h00, 8'h7f, 8'h80, 1'b1, 1'b1);
        alu(mie_pkg::OP_INC_WORK, 8'h00, 8'hff, 8'h00, 1'b0, 1'b1);
    endtask

    task automatic bcd(input logic [7:0] w, input logic [7:0] res,
            input logic cy);
        alu(mie_pkg::OP_COPY_IMM, w, 8'h00, w, 1'b0, 1'b0);
        expCarry = cy;
        alu(mie_pkg::OP_BCD_ADJ, 8'h00, 8'h00, res, 1'b1, 1'b0);
    endtask

    task automatic t_power;
        logic [12:0] p0;
        logic [7:0] w0;
        p0 = programCounter;
        w0 = workRegister;
        exec(mie_pkg::OP_POWER_DOWN);
        fx = f0;
        fx.sleepFlag = 1'b1;
        fx.watchdogExpired = 1'b0;
        `CHK(flags, fx)
        `CHK(watchdogCounter, 8'h00)
        `CHK(programCounter, p0 + 13'h0001)
        repeat (20) @(negedge clock);
        `CHK(clockGateOff, 1'b1)
        `CHK(instrReady, 1'b0)
        `CHK(workRegister, w0)
        wakeUp = 1'b1;
        @(negedge clock);
        wakeUp = 1'b0;
        `CHK(clockGateOff, 1'b0)
        repeat (600) @(negedge clock);
    endtask

    task automatic t_wdt;
        t_power;
        exec(mie_pkg::OP_WDT_PRE1);
        `CHK(watchdogPreclearFirstSeen, 1'b1)
        `CHK(watchdogCounter == 8'h00, 1'b0)
        `CHK(flags, f0)
        exec(mie_pkg::OP_WDT_PRE1);
        `CHK(flags, f0)
        exec(mie_pkg::OP_WDT_PRE2);
        fx = f0;
        fx.sleepFlag = 1'b0;
        fx.watchdogExpired = 1'b0;
        `CHK(flags, fx)
        `CHK(watchdogCounter, 8'h00)
        t_power;
        exec(mie_pkg::OP_WDT_PRE2);
        `CHK(watchdogPreclearSecondSeen, 1'b1)
        `CHK(watchdogCounter == 8'h00, 1'b0)
        `CHK(flags, f0)
        exec(mie_pkg::OP_WDT_CLEAR);
        fx = f0;
        fx.sleepFlag = 1'b0;
        fx.watchdogExpired = 1'b0;
        `CHK(flags, fx)
        `CHK(watchdogCounter, 8'h00)
    endtask

    task automatic t_flow;
        exec(mie_pkg::OP_JUMP, 8'h00, 13'h1555);
        `CHK(programCounter, 13'h1555)
        `CHK(flags, f0)
        wait_ready;
        `CHK(lowCnt, 7)
        exec(mie_pkg::OP_IDLE);
        `CHK(programCounter, 13'h1556)
        `CHK(flags, f0)
        push_pc(13'h0abc);
        push_pc(13'h0123);
        exec(mie_pkg::OP_SUB_EXIT_IMM, 8'h66);
        `CHK(programCounter, 13'h0123)
        `CHK(workRegister, 8'h66)
        wait_ready;
        `CHK(lowCnt, 7)
        exec(mie_pkg::OP_IRQ_EXIT);
        `CHK(programCounter, 13'h0abc)
        `CHK(globalIrqEnable, 1'b1)
        wait_ready;
        irqAccept = 1'b1;
        @(negedge clock);
        irqAccept = 1'b0;
        push_pc(13'h0042);
        exec(mie_pkg::OP_SUB_EXIT);
        `CHK(programCounter, 13'h0042)
        `CHK(flags, f0)
        alu(mie_pkg::OP_COPY_IMM, 8'h40, 8'h00, 8'h40, 1'b0, 1'b0);
        exec(mie_pkg::OP_COPY_WORK_TO_MEM, 8'h00, 13'h0000, 8'h06);
        `CHK(programCounter, 13'h0040)
        wait_ready;
        `CHK(lowCnt, 7)
    endtask

    initial begin
        forever #5 clock = ~clock;
    end

    initial begin
        repeat (12) @(negedge clock);
        `CHK(instrReady, 1'b0)
        `CHK(workRegister, mie_pkg::RST_WORK_REG)
        `CHK(flags, mie_pkg::RST_FLAGS)
        sys_rst = 1'b0;
        t_data;
        bcd(8'h45, 8'h45, 1'b0);
        bcd(8'h0b, 8'h11, 1'b0);
        bcd(8'h9a, 8'h00, 1'b1);
        bcd(8'h12, 8'h72, 1'b1);
        t_wdt;
        t_flow;
        tally_and_finish;
    end
endmodule
